// *** mask_rom_select_decoder.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "rom_select_consts.svh"

// Overview of operation
// - Select inputs: high, low or ignored
// - Ignored inputs drop out of selection
// - Read strobe always active low
// - Chain enable: active high or ignored
// - Latch pulse default high, optionally low
// - Contents are one 1024-word block
// - Six high lines pick one block
// - High option needs 1, low needs 0
// - All low options: lowest kilobyte
// - All high options: highest kilobyte
// - Ignored address bits mirror the block
// - Chain out feeds RAM select
// - Unused words filled with zeros
module mask_rom_select_decoder
  import rom_select_pkg::*;
#(
  parameter mask_options_type MASK = '0,
  parameter int ADDR_BITS = `ROM_ADDR_BITS,
  parameter int DATA_BITS = `DATA_BITS
) (
  input  wire logic                  i_clk,        // 10 MHz clock
  input  wire logic                  i_rstn,       // Async reset, low
  input  wire bus_ctrl_type          i_ctrl,       // Bus controls (pins)
  input  wire logic [7:0]            i_mux_addr,   // Multiplexed address
  input  wire logic [ADDR_BITS-1:0]  i_low_addr,   // Low-order address
  input  wire logic                  i_load_we,    // Content load strobe
  input  wire logic [DATA_BITS-1:0]  i_load_data,  // Content load word
  output logic                       o_selected,   // ROM block selected
  output logic                       o_chain_enable_out, // To next device
  output logic [DATA_BITS-1:0]       o_data,       // Read data
  output logic                       o_data_oe_n   // Data drive, low=on
);

  // ****************************************
  // Reset release
  // ****************************************
  logic [1:0] rst_sync;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  wire rstn = rst_sync[1];

  // ****************************************
  // Pin synchronisers, three stages each
  // ****************************************
  localparam int NPIN = $bits(bus_ctrl_type) + 8;
  wire  [NPIN-1:0] pin_raw = {i_ctrl, i_mux_addr};
  logic [NPIN-1:0] s1;
  logic [NPIN-1:0] s2;
  logic [NPIN-1:0] s3;
  logic [NPIN-1:0] pin_clean;

  genvar g;
  generate
    for (g = 0; g < NPIN; g++) begin : g_sync
      always_ff @(posedge i_clk or negedge rstn) begin
        if (!rstn) begin
          s1[g]        <= 1'b0;
          s2[g]        <= 1'b0;
          s3[g]        <= 1'b0;
          pin_clean[g] <= 1'b0;
        end else begin
          s1[g] <= pin_raw[g];
          s2[g] <= s1[g];
          s3[g] <= s2[g];
          // Change counts only when stages two and three agree
          if (s2[g] == s3[g]) begin
            pin_clean[g] <= s3[g];
          end
        end
      end
    end
  endgenerate

  bus_ctrl_type ctrl;
  wire  [7:0]   mux_addr;
  assign {ctrl, mux_addr} = pin_clean;

  // ****************************************
  // Address latch
  // ****************************************
  // Latch pulse polarity follows the mask; default is the direct
  // processor pulse, active high
  wire latch_level = MASK.latch_low ? ~ctrl.address_latch_pulse
                                    : ctrl.address_latch_pulse;
  logic [`HI_ADDR_BITS-1:0] hi_addr;

  // High byte stands on the bus only while the pulse is up, and the
  // low byte replaces it in the very synced cycle in which the pulse
  // drops; so follow the bus while the pulse is up and keep the last
  // value, rather than sampling after the fall
  always_ff @(posedge i_clk or negedge rstn) begin
    if (!rstn) begin
      hi_addr <= '0;
    end else begin
      if (latch_level) begin
        hi_addr <= mux_addr[7:2];
      end
    end
  end

  // ****************************************
  // Term decode
  // ****************************************
  logic [`HI_ADDR_BITS-1:0] addr_ok;
  logic sel_a_ok;
  logic sel_b_ok;
  logic chain_ok;

  // Each address term wants 1, 0 or nothing; ignored bits mirror
  // the block, all low gives 0000-03FF and all high FC00-FFFF
  generate
    for (g = 0; g < `HI_ADDR_BITS; g++) begin : g_addr
      term_match u_addr (
        .i_level  (hi_addr[g]),
        .i_option (MASK.hi_addr[g]),
        .o_match  (addr_ok[g])
      );
    end
  endgenerate

  term_match u_sel_a (
    .i_level  (ctrl.select_a),
    .i_option (MASK.select_a),
    .o_match  (sel_a_ok)
  );
  term_match u_sel_b (
    .i_level  (ctrl.select_b),
    .i_option (MASK.select_b),
    .o_match  (sel_b_ok)
  );

  // Chain input knows only active high or ignored
  wire chain_ignored = (MASK.chain_in != `OPT_ACTIVE_HIGH);
  assign chain_ok = chain_ignored | ctrl.chain_enable_in;

  wire addr_hit = &addr_ok;
  wire selected = addr_hit & sel_a_ok & sel_b_ok & chain_ok;
  // Read strobe has no option: always low true
  wire read_now = selected & ~ctrl.memory_read_strobe_n;

  // Pass the chain on only when enabled here and this block is not
  // addressed, so a RAM at the end answers only outside the ROMs
  wire next_chain = chain_ok & ~(addr_hit & sel_a_ok & sel_b_ok);

  // ****************************************
  // Content store
  // ****************************************
  // One contiguous block; words never loaded read as zero, which is
  // the low power fill for unused locations
  logic [DATA_BITS-1:0] mem [0:(1 << ADDR_BITS)-1];
  logic [ADDR_BITS-1:0] load_ptr;
  logic [DATA_BITS-1:0] rd_word;
  // One flag per word: the array itself has no reset, so a word
  // that was never loaded must be forced to the zero fill here
  logic [(1 << ADDR_BITS)-1:0] loaded;

  always_ff @(posedge i_clk) begin
    if (i_load_we) begin
      mem[load_ptr] <= i_load_data;
    end
    rd_word <= loaded[i_low_addr] ? mem[i_low_addr] : '0;
  end

  always_ff @(posedge i_clk or negedge rstn) begin
    if (!rstn) begin
      load_ptr <= '0;
      loaded   <= '0;
    end else if (i_load_we) begin
      load_ptr         <= load_ptr + 1'b1;
      loaded[load_ptr] <= 1'b1;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  always_ff @(posedge i_clk or negedge rstn) begin
    if (!rstn) begin
      o_selected         <= 1'b0;
      o_chain_enable_out <= 1'b0;
      o_data             <= '0;
      o_data_oe_n        <= 1'b1;
    end else begin
      o_selected         <= selected;
      o_chain_enable_out <= next_chain;
      o_data             <= read_now ? rd_word : '0;
      o_data_oe_n        <= ~read_now;
    end
  end

endmodule : mask_rom_select_decoder
`default_nettype wire

// *** rom_select_consts.svh ***
`ifndef ROM_SELECT_CONSTS_SVH
`define ROM_SELECT_CONSTS_SVH

// Option codes for one programmable select or address input
`define OPT_ACTIVE_HIGH 2'h1
`define OPT_ACTIVE_LOW  2'h2
`define OPT_IGNORED     2'h0

// Geometry: 1024 words, six high-order lines pick one of 64 blocks
`define ROM_WORDS       1024
`define ROM_ADDR_BITS   10
`define HI_ADDR_BITS    6
`define DATA_BITS       8

`endif

// *** rom_select_pkg.sv ***
package rom_select_pkg;
  typedef logic [1:0] option_type;

  // Mask options fixed at manufacture
  typedef struct packed {
    option_type       select_a;
    option_type       select_b;
    option_type       chain_in;
    logic             latch_low;
    option_type [5:0] hi_addr;
  } mask_options_type;

  typedef struct packed {
    logic       select_a;
    logic       select_b;
    logic       chain_enable_in;
    logic       memory_read_strobe_n;
    logic       address_latch_pulse;
  } bus_ctrl_type;
endpackage : rom_select_pkg

// *** term_match.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "rom_select_consts.svh"

// ****************************************
// One programmable term: high, low or ignored
// ****************************************
module term_match
  import rom_select_pkg::*;
(
  input  wire logic       i_level,   // Sampled input level
  input  wire option_type i_option,  // Mask option for this input
  output logic            o_match    // Term satisfied
);
  wire want_high = (i_option == `OPT_ACTIVE_HIGH);
  wire want_low  = (i_option == `OPT_ACTIVE_LOW);
  // Ignored and unused codes always pass
  assign o_match = want_high ? i_level : (want_low ? ~i_level : 1'b1);
endmodule : term_match
`default_nettype wire

// *** rom_dec_chk_asserts.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "rom_select_consts.svh"
// ****
// Port relations
// ****
module rom_dec_chk
  import rom_select_pkg::*;
#(parameter mask_options_type MASK = '0) (
  input wire logic                 i_clk,              // Clock
  input wire logic                 i_rstn,             // Reset, low
  input wire bus_ctrl_type         i_ctrl,             // Bus controls
  input wire logic                 o_selected,         // Selected
  input wire logic                 o_chain_enable_out, // Chain out
  input wire logic [`DATA_BITS-1:0] o_data,            // Read data
  input wire logic                 o_data_oe_n         // Drive, low=on
);
  function automatic logic miss(input logic l, input option_type o);
    return (o == `OPT_ACTIVE_HIGH) ? !l : (o == `OPT_ACTIVE_LOW) ? l : 1'b0;
  endfunction : miss
  wire logic bad_a = miss(i_ctrl.select_a, MASK.select_a);
  wire logic bad_b = miss(i_ctrl.select_b, MASK.select_b);
  wire logic bad_c = (MASK.chain_in == `OPT_ACTIVE_HIGH) &&
                     !i_ctrl.chain_enable_in;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  property p_sel_a; bad_a [*8] |-> !o_selected; endproperty
  a_sel_a: assert property (p_sel_a) else $error("sel a");
  property p_sel_b; bad_b [*8] |-> !o_selected; endproperty
  a_sel_b: assert property (p_sel_b) else $error("sel b");
  property p_chain; bad_c [*8] |-> !o_selected; endproperty
  a_chain: assert property (p_chain) else $error("chain");
  property p_strb; i_ctrl.memory_read_strobe_n [*8] |-> o_data_oe_n; endproperty
  a_strb: assert property (p_strb) else $error("strobe");
  property p_fell;
    $fell(o_data_oe_n) |-> !$past(i_ctrl.memory_read_strobe_n, 2);
  endproperty
  a_fell: assert property (p_fell) else $error("drive");
  property p_mux; o_selected |-> !o_chain_enable_out; endproperty
  a_mux: assert property (p_mux) else $error("chain sel");
  property p_oe; !o_data_oe_n |-> o_selected; endproperty
  a_oe: assert property (p_oe) else $error("oe");
  property p_zero; o_data_oe_n |-> o_data == '0; endproperty
  a_zero: assert property (p_zero) else $error("data");
endmodule : rom_dec_chk
bind mask_rom_select_decoder rom_dec_chk #(.MASK(MASK)) u_chk (
  .i_clk(i_clk), .i_rstn(i_rstn), .i_ctrl(i_ctrl), .o_selected(o_selected),
  .o_chain_enable_out(o_chain_enable_out), .o_data(o_data),
  .o_data_oe_n(o_data_oe_n));
`default_nettype wire

// *** cpu_bus_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// ****
// Processor bus cycle
// ****
module cpu_bus_model
  import rom_select_pkg::*;
(
  input  wire logic    i_clk,      // Clock
  output var bus_ctrl_type o_ctrl,     // Bus controls
  output logic [7:0]       o_mux_addr, // Multiplexed address
  output logic [9:0]       o_low_addr  // Low-order address
);
  initial begin
    o_ctrl = 5'h0A;
    o_mux_addr = 8'h00;
    o_low_addr = 10'h000;
  end
  task automatic start(input logic [15:0] a, input logic [2:0] s);
    @(posedge i_clk);
    o_mux_addr <= a[15:8];
    o_low_addr <= a[9:0];
    o_ctrl <= {s, 1'b1, 1'b1};
    repeat (4) @(posedge i_clk);
    o_ctrl.address_latch_pulse <= 1'b0;
    o_mux_addr <= a[7:0];
    repeat (4) @(posedge i_clk);
    o_ctrl.memory_read_strobe_n <= 1'b0;
  endtask : start
  task automatic stop();
    o_ctrl <= 5'h0A;
    o_mux_addr <= ~o_mux_addr;
    @(posedge i_clk);
  endtask : stop
endmodule : cpu_bus_model
`default_nettype wire

// *** mask_rom_select_decoder_tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "rom_select_consts.svh"
module mask_rom_select_decoder_tb_top
  import rom_select_pkg::*;
();
  // Lowest block address bit ignored, so the block also shows at 0400
  localparam mask_options_type MASK = '{select_a: `OPT_ACTIVE_HIGH,
    select_b: `OPT_ACTIVE_LOW, chain_in: `OPT_ACTIVE_HIGH, latch_low: 1'b0,
    hi_addr: {{5{`OPT_ACTIVE_LOW}}, `OPT_IGNORED}};
  logic clk = 1'b0, rstn = 1'b0, we = 1'b0, sel, chain_enable_out, oen;
  logic [7:0] ld = 8'h00, mux, data, mem [4];
  logic [9:0] low;
  bus_ctrl_type ctrl;
  int fails = 0, total_checks = 0;
  logic [31:0] seed = 32'h7A46;
  logic [18:0] corner [5] = '{19'h04025, 19'h08005, 19'h00034,
                              19'h00011, 19'h0010D};
  always #50 clk = ~clk;
  cpu_bus_model cpu (.i_clk(clk), .o_ctrl(ctrl), .o_mux_addr(mux),
                     .o_low_addr(low));
  mask_rom_select_decoder #(.MASK(MASK)) dut (.i_clk(clk), .i_rstn(rstn),
    .i_ctrl(ctrl), .i_mux_addr(mux), .i_low_addr(low), .i_load_we(we),
    .i_load_data(ld), .o_selected(sel), .o_chain_enable_out(chain_enable_out),
    .o_data(data), .o_data_oe_n(oen));
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : nxt
  function automatic logic [9:0] want(input logic [15:0] a, input logic [2:0] s);
    logic hit;
    hit = s[2] && !s[1] && s[0] && a[15:11] == 5'h00;
    return {hit, s[0] && !hit, (hit && a[9:2] == 8'h00) ? mem[a[1:0]] : 8'h00};
  endfunction : want
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%0h want=%0h", $time, seen, exp);
    end
  endtask : check
  task automatic print_verdict();
    $display("checks=%0d fails=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (3000) @(posedge clk);
    fails++;
    print_verdict();
  end
  initial begin
    logic [15:0] a;
    logic [2:0]  s;
    logic [9:0]  e;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      seed = nxt(seed);
      mem[i] = seed[7:0];
      we <= 1'b1;
      ld <= seed[7:0];
      @(posedge clk);
    end
    we <= 1'b0;
    $display("load done");
    for (int i = 0; i < 40; i++) begin
      seed = nxt(seed);
      {a, s} = {seed[15:0], ~(seed[22] & seed[23]), seed[24] & seed[25],
                ~(seed[26] & seed[27])};
      if (seed[20]) a[15:11] = 5'h00;
      if (seed[21]) a[9:2] = 8'h00;
      if (i < 5) {a, s} = corner[i];
      cpu.start(a, s);
      repeat (10) @(posedge clk);
      e = want(a, s);
      check(sel, e[9]);
      if (s[2] && !s[1]) check(chain_enable_out, e[8]);
      check(data, e[7:0]);
      check(oen, !e[9]);
      cpu.stop();
      repeat (8) @(posedge clk);
      check(oen, 1'b1);
      $display("test %0d done", i);
    end
    print_verdict();
  end
endmodule : mask_rom_select_decoder_tb_top
`default_nettype wire
